// File: logic/ssl_exec.sv
// execution logic for push literal, subtract from pointer, subtract and return, indexed move
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE1] push writes the 8-bit literal to data memory at the stack pointer.
// [RULE2] after the push store, the whole stack pointer drops by one.
// [RULE3] subtract-from-pointer takes the 6-bit literal from the pointer chosen by the two-bit field.
// [RULE4] a selector field of 11 decodes as subtract-and-return, working on the stack pointer.
// [RULE5] subtract-and-return subtracts the literal from the stack pointer and loads the pc from the return stack top.
// [RULE6] subtract-and-return takes two instruction cycles, the second one a no-operation.
// [RULE7] indexed move adds two 7-bit offsets to the stack pointer for source and destination and copies the byte.
// [RULE8] an indexed move source on an indirect register reads 00h, a destination there makes it a no-operation.
// [RULE9] push and subtract-from-pointer take one cycle, and no instruction here touches status flags.
module ssl_exec
  import ssl_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int PW = PC_W
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  output logic INSTR_READY,
  output logic CYCLE_STROBE,
  output logic BUSY,
  output logic [AW-1:0] PTR0,
  output logic [AW-1:0] PTR1,
  output logic [AW-1:0] STACK_PTR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [AW-1:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  input wire logic [PW-1:0] RET_TOP,
  output logic RET_POP,
  output logic PC_LOAD,
  output logic [PW-1:0] PC_VALUE,
  output logic FLAGS_WE
);
  // indirect access register window
  function automatic logic is_indirect(input logic [AW-1:0] a);
    return (a >= IND_LO) && (a <= IND_HI);
  endfunction : is_indirect

  // offset add wraps inside the data space
  function automatic logic [AW-1:0] offset_addr(
    input logic [AW-1:0] base,
    input logic [6:0] off
  );
    return AW'(base + AW'(off));
  endfunction : offset_addr

  // literal is unsigned, so a low pointer wraps to the top
  function automatic logic [AW-1:0] sub_lit(
    input logic [AW-1:0] p,
    input logic [5:0] k
  );
    return AW'(p - AW'(k));
  endfunction : sub_lit

  function automatic logic is_push(input logic [15:0] w);
    return w[15:8] == OPC_PUSH;
  endfunction : is_push

  function automatic logic is_sub_ptr(input logic [15:0] w);
    return w[15:8] == OPC_SUBP;
  endfunction : is_sub_ptr

  function automatic logic is_move_src(input logic [15:0] w);
    return w[15:7] == {OPC_MOVE1, 1'b1};
  endfunction : is_move_src

  // any 1111 word closes a pending move, even one shaped like a push
  function automatic logic is_move_dst(input logic [15:0] w);
    return w[15:12] == OPC_MOVE2;
  endfunction : is_move_dst

  typedef struct packed {
    ssl_state_e state;
    logic [AW-1:0] ptr0;
    logic [AW-1:0] ptr1;
    logic [AW-1:0] ptr2;
    logic [6:0] src_off;
    logic mem_rd;
    logic mem_wr;
    logic [AW-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic ret_pop;
    logic pc_load;
    logic [PW-1:0] pc_value;
  } ssl_exec_s;

  ssl_exec_s st_reg;
  ssl_exec_s st_next;
  logic q_last;
  logic take;
  logic do_push;
  logic do_sub;
  logic do_move_src;
  logic do_move_dst;
  logic [1:0] sel;
  logic [5:0] lit6;
  logic [AW-1:0] word_addr;
  logic [AW-1:0] held_src;
  logic [7:0] src_byte;

  ssl_qphase u_qphase (
    .clk(CLK),
    .rst_b(RST_B),
    .q_last(q_last)
  );

  assign take = INSTR_READY && INSTR_VALID;
  assign do_push = take && is_push(INSTR_WORD); // RULE1
  assign do_sub = take && is_sub_ptr(INSTR_WORD); // RULE3
  assign do_move_src = take && is_move_src(INSTR_WORD); // RULE7
  assign do_move_dst = take && is_move_dst(INSTR_WORD); // RULE7
  assign sel = INSTR_WORD[7:6];
  assign lit6 = INSTR_WORD[5:0];
  assign word_addr = offset_addr(st_reg.ptr2, INSTR_WORD[6:0]); // RULE7
  // stack pointer holds still while a move waits, so the source is rebuilt from its offset
  assign held_src = offset_addr(st_reg.ptr2, st_reg.src_off); // RULE7
  // indirect source reads as zero without a real read
  assign src_byte = is_indirect(held_src) ? ZERO_BYTE : MEM_RDATA; // RULE8

  always_comb begin
    st_next = st_reg;
    st_next.mem_rd = 1'b0;
    st_next.mem_wr = 1'b0;
    st_next.ret_pop = 1'b0;
    st_next.pc_load = 1'b0;
    // state moves only at the end of an instruction cycle
    if (q_last) begin
      case (st_reg.state)
        SSL_IDLE: begin
          if (do_push) begin
            st_next.mem_wr = 1'b1; // RULE1
            st_next.mem_addr = st_reg.ptr2; // RULE1
            st_next.mem_wdata = INSTR_WORD[7:0]; // RULE1
            st_next.ptr2 = AW'(st_reg.ptr2 - 1'b1); // RULE2
          end else if (do_sub) begin
            case (sel)
              2'h0: begin
                st_next.ptr0 = sub_lit(st_reg.ptr0, lit6); // RULE3
              end
              2'h1: begin
                st_next.ptr1 = sub_lit(st_reg.ptr1, lit6); // RULE3
              end
              SEL_STACK: begin
                st_next.ptr2 = sub_lit(st_reg.ptr2, lit6); // RULE3
              end
              SEL_RET: begin
                st_next.ptr2 = sub_lit(st_reg.ptr2, lit6); // RULE4 RULE5
                st_next.pc_load = 1'b1; // RULE5
                st_next.pc_value = RET_TOP; // RULE5
                st_next.ret_pop = 1'b1; // RULE5
                st_next.state = SSL_RETNOP; // RULE6
              end
              default: begin
                st_next.state = SSL_IDLE;
              end
            endcase
          end else if (do_move_src) begin
            // source read goes out now, its data is taken at the next cycle end
            st_next.src_off = INSTR_WORD[6:0]; // RULE7
            st_next.mem_addr = word_addr; // RULE7
            st_next.mem_rd = !is_indirect(word_addr); // RULE8
            st_next.state = SSL_MOVE2;
          end else begin
            // unknown words retire as a one-cycle no-operation
            st_next.state = SSL_IDLE; // RULE9
          end
        end
        SSL_RETNOP: begin
          // fetch address changes here, so no word is taken
          st_next.state = SSL_IDLE; // RULE6
        end
        SSL_MOVE2: begin
          if (do_move_dst) begin
            st_next.mem_wdata = src_byte; // RULE8
            st_next.mem_addr = word_addr; // RULE7
            st_next.mem_wr = !is_indirect(word_addr); // RULE8
            st_next.state = SSL_IDLE;
          end
        end
        default: begin
          st_next.state = SSL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg <= '0;
      st_reg.state <= SSL_IDLE;
      st_reg.ptr0 <= PTR_RESET;
      st_reg.ptr1 <= PTR_RESET;
      st_reg.ptr2 <= PTR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ready only outside the return no-operation cycle
  assign INSTR_READY = q_last && (st_reg.state != SSL_RETNOP); // RULE6 RULE9
  assign CYCLE_STROBE = q_last;
  assign BUSY = (st_reg.state != SSL_IDLE);

  assign PTR0 = st_reg.ptr0;
  assign PTR1 = st_reg.ptr1;
  assign STACK_PTR = st_reg.ptr2;

  assign MEM_RD = st_reg.mem_rd;
  assign MEM_WR = st_reg.mem_wr;
  assign MEM_ADDR = st_reg.mem_addr;
  assign MEM_WDATA = st_reg.mem_wdata;

  assign RET_POP = st_reg.ret_pop;
  assign PC_LOAD = st_reg.pc_load;
  assign PC_VALUE = st_reg.pc_value;
  assign FLAGS_WE = 1'b0; // RULE9
endmodule : ssl_exec
`default_nettype wire

// File: pkg/ssl_pkg.sv
// constants and types for the software stack literal instruction group
package ssl_pkg;
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam int QCNT_W = 2;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [7:0] OPC_PUSH = 8'hFA;
  localparam logic [7:0] OPC_SUBP = 8'hE9;
  localparam logic [7:0] OPC_MOVE1 = 8'hEB;
  localparam logic [3:0] OPC_MOVE2 = 4'hF;
  localparam logic [1:0] SEL_STACK = 2'h2;
  localparam logic [1:0] SEL_RET = 2'h3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] IND_LO = 12'hFE0;
  localparam logic [ADDR_W-1:0] IND_HI = 12'hFEF;
  typedef enum logic [2:0] {
    SSL_IDLE = 3'b000,
    SSL_EXEC = 3'b001,
    SSL_RETNOP = 3'b010,
    SSL_MOVE2 = 3'b011,
    SSL_MOVE_WR = 3'b100
  } ssl_state_e;
endpackage : ssl_pkg

// File: logic/ssl_qphase.sv
// quarter-cycle divider: one-cycle pulse at the last quarter of each instruction cycle
`timescale 1ns/1ps
`default_nettype none
module ssl_qphase
  import ssl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  output logic q_last
);
  typedef struct packed {
    logic [QCNT_W-1:0] cnt;
  } ssl_q_s;
  ssl_q_s st_reg;
  ssl_q_s st_next;
  always_comb begin
    st_next = st_reg;
    st_next.cnt = QCNT_W'(st_reg.cnt + 1'b1);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q_last = (st_reg.cnt == Q_LAST);
endmodule : ssl_qphase
`default_nettype wire

// File: verification/ssl_exec_sva.sv
// checker for the software stack literal group
`timescale 1ns/1ps
`default_nettype none
module ssl_exec_sva
  import ssl_pkg::*;
#(parameter int AW = ADDR_W) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  input wire logic INSTR_READY,
  input wire logic CYCLE_STROBE,
  input wire logic BUSY,
  input wire logic [AW-1:0] STACK_PTR,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [AW-1:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  input wire logic RET_POP,
  input wire logic PC_LOAD
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // single words only count in idle; a pending move takes 1111 words as its second word
  wire tk = CYCLE_STROBE && INSTR_VALID && INSTR_READY && !BUSY;
  wire dtk = CYCLE_STROBE && INSTR_VALID && INSTR_READY && BUSY && INSTR_WORD[15:12] == OPC_MOVE2;
  wire [AW-1:0] src = STACK_PTR + AW'(INSTR_WORD[6:0]);
  wire hit = src >= IND_LO && src <= IND_HI;
  wire psh = tk && INSTR_WORD[15:8] == OPC_PUSH;
  wire sub = tk && INSTR_WORD[15:8] == OPC_SUBP;
  wire ret = sub && INSTR_WORD[7:6] == SEL_RET;
  wire mov = tk && INSTR_WORD[15:7] == {OPC_MOVE1, 1'b1};
  push_store_a: assert property (psh |=> MEM_WR && MEM_ADDR == $past(STACK_PTR) &&
    MEM_WDATA == $past(INSTR_WORD[7:0])) else $error("push store wrong");
  push_dec_a: assert property (psh |=> STACK_PTR == $past(STACK_PTR) - 1'b1)
    else $error("push pointer not decremented");
  sub_stack_a: assert property (sub && INSTR_WORD[7:6] == SEL_STACK |=>
    STACK_PTR == $past(STACK_PTR) - $past(INSTR_WORD[5:0])) else $error("pointer subtract wrong");
  ret_decode_a: assert property (ret |=> PC_LOAD && RET_POP &&
    STACK_PTR == $past(STACK_PTR) - $past(INSTR_WORD[5:0])) else $error("return wrong");
  ret_gap_a: assert property (ret |=> BUSY ##3 CYCLE_STROBE && !INSTR_READY)
    else $error("return second cycle missing");
  move_read_a: assert property (mov && !hit |=> MEM_RD && MEM_ADDR == $past(src))
    else $error("move source read wrong");
  move_zero_a: assert property (mov && hit |=> !MEM_RD)
    else $error("move read an indirect register");
  one_cycle_a: assert property (psh || (sub && !ret) |=> !BUSY)
    else $error("single cycle op left busy");
  move_write_a: assert property (dtk && !hit |=> MEM_WR && MEM_ADDR == $past(src))
    else $error("move destination write wrong");
  move_skip_a: assert property (dtk && hit |=> !MEM_WR)
    else $error("move wrote an indirect register");
endmodule : ssl_exec_sva
bind ssl_exec ssl_exec_sva #(.AW(AW)) u_ssl_exec_sva (
  .CLK(CLK),
  .RST_B(RST_B),
  .INSTR_VALID(INSTR_VALID),
  .INSTR_WORD(INSTR_WORD),
  .INSTR_READY(INSTR_READY),
  .CYCLE_STROBE(CYCLE_STROBE),
  .BUSY(BUSY),
  .STACK_PTR(STACK_PTR),
  .MEM_RD(MEM_RD),
  .MEM_WR(MEM_WR),
  .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA),
  .RET_POP(RET_POP),
  .PC_LOAD(PC_LOAD)
);
`default_nettype wire

// File: verification/test_software_stack_literal_ops.sv
// bench for the software stack literal group
`timescale 1ns/1ps
`default_nettype none
module test_software_stack_literal_ops;
  import ssl_pkg::*;
  logic CLK = 1'b0, RST_B = 1'b0, INSTR_VALID = 1'b0;
  logic [15:0] INSTR_WORD = 16'h0000;
  logic [7:0] MEM_RDATA = 8'h33, MEM_WDATA;
  logic [20:0] RET_TOP = 21'h1_2345, PC_VALUE;
  logic [11:0] PTR0, PTR1, STACK_PTR, MEM_ADDR;
  logic INSTR_READY, CYCLE_STROBE, BUSY, MEM_RD, MEM_WR, RET_POP, PC_LOAD, FLAGS_WE;
  int bad_count = 0, n_checks = 0;
  time tk;
  ssl_exec u_ssl_exec (
    .CLK(CLK),
    .RST_B(RST_B),
    .INSTR_VALID(INSTR_VALID),
    .INSTR_WORD(INSTR_WORD),
    .INSTR_READY(INSTR_READY),
    .CYCLE_STROBE(CYCLE_STROBE),
    .BUSY(BUSY),
    .PTR0(PTR0),
    .PTR1(PTR1),
    .STACK_PTR(STACK_PTR),
    .MEM_RD(MEM_RD),
    .MEM_WR(MEM_WR),
    .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA),
    .RET_TOP(RET_TOP),
    .RET_POP(RET_POP),
    .PC_LOAD(PC_LOAD),
    .PC_VALUE(PC_VALUE),
    .FLAGS_WE(FLAGS_WE)
  );
  initial forever #2 CLK = ~CLK;
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task wrap_up;
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  // bounded wait: a word is offered only until the strobe accepts it
  task issue(input logic [15:0] w);
    @(negedge CLK);
    INSTR_WORD = w;
    INSTR_VALID = 1'b1;
    for (int i = 0; i < 12 && !(CYCLE_STROBE === 1'b1 && INSTR_READY === 1'b1); i++)
      @(negedge CLK);
    chk({CYCLE_STROBE, INSTR_READY}, 2'b11);
    @(posedge CLK);
    tk = $time;
    @(negedge CLK);
    INSTR_VALID = 1'b0;
  endtask : issue
  task t_sub;
    for (int f = 0; f < 3; f++) begin
      issue({OPC_SUBP, f[1:0], 6'h3F});
      chk(f == 0 ? PTR0 : f == 1 ? PTR1 : STACK_PTR, 12'hFC1);
      chk(BUSY, 1'b0);
    end
  endtask : t_sub
  task t_push;
    issue(16'hFA08);
    chk({MEM_WR, MEM_ADDR, MEM_WDATA}, {1'b1, 12'hFC1, 8'h08});
    issue(16'hFA5A);
    chk({MEM_WR, MEM_ADDR, STACK_PTR, BUSY}, {1'b1, 12'hFC0, 12'hFBF, 1'b0});
  endtask : t_push
  task t_ret;
    time t0;
    issue(16'hE9E3);
    t0 = tk;
    chk({PC_LOAD, RET_POP, PC_VALUE}, {2'b11, 21'h1_2345});
    chk(STACK_PTR, 12'hF9C);
    issue(16'hE901);
    chk(32'(tk - t0), 32);
    chk(PTR0, 12'hFC0);
  endtask : t_ret
  // move cases: plain copy, then indirect window cases: source reads zero, destination suppresses the write
  task t_move;
    issue(16'hEB85);
    chk({MEM_RD, MEM_ADDR, BUSY}, {1'b1, 12'hFA1, 1'b1});
    issue(16'hF006);
    chk({MEM_WR, MEM_ADDR, MEM_WDATA}, {1'b1, 12'hFA2, 8'h33});
    issue(16'hEBC4);
    chk(MEM_RD, 1'b0);
    issue(16'hF006);
    chk({MEM_WR, MEM_WDATA}, {1'b1, 8'h00});
    issue(16'hEB85);
    issue(16'hF044);
    chk(MEM_WR, 1'b0);
  endtask : t_move
  // reset in mid-move: pending move dropped, pointers cleared
  task t_reset;
    issue(16'hEB85);
    @(negedge CLK);
    RST_B = 1'b0;
    @(negedge CLK);
    chk({PTR0, PTR1}, 24'h00_0000);
    chk({STACK_PTR, BUSY}, 13'h0000);
    RST_B = 1'b1;
    issue(16'hFA77);
    chk({MEM_ADDR, MEM_WDATA, STACK_PTR}, {12'h000, 8'h77, 12'hFFF});
  endtask : t_reset
  initial begin
    repeat (16) @(negedge CLK);
    RST_B = 1'b1;
    chk(STACK_PTR, 12'h000);
    t_sub;
    t_push;
    t_ret;
    t_move;
    t_reset;
    chk(FLAGS_WE, 1'b0);
    wrap_up;
  end
  initial begin
    #4000;
    bad_count++;
    wrap_up;
  end
endmodule : test_software_stack_literal_ops
`default_nettype wire
